// >>> src/poc_controller.sv
// On/off controller: wake input handling, manual reset, standby and power states
//
// Overview of operation
// - Push-button: low held hold-time powers down.
// - Slide-switch: high held hold-time powers down.
// - Logic mode: high input powers down at once.
// - Every manual reset sets manual reset flag.
// - Manual reset works only in Resource On.
// - Debounce both edges over full period.
// - Pullup disable 0 enables pullup, 1 floats.
// - Unmasked interrupt drives open-drain output low.
// - Masks come up set; host clears wanted ones.
// - Shutdown: bias, port off; flags retained.
// - Wake on edge, low level, or wake flag.
// - Power up only with no fault flags.
// - Resource On after power-up completes.
// - Held reset below POR, then Shutdown.
// - Standby command powers down into Standby.
// - Exit-standby command returns to Resource On.
// - Host powers off by command or input.
// - Mode 0 button, 1 slide, 2 logic.
// - Debounce length set by programmable setting.
// - Cold reset, power-off, manual reset request down.
// - Standby keeps forced outputs, bias, port on.
`timescale 1ns/10ps
`default_nettype none
module poc_controller
   import poc_pkg::*;
#(
   parameter longint MANUAL_RESET_FLAG_HOLD  = MANUAL_RESET_FLAG_HOLD_CYC,
   parameter int     DB_CYC_0   = DEBOUNCE_CYC_0,
   parameter int     SEQ_CYC    = SEQ_STEP_CYC,
   parameter logic [1:0] MASK_INIT = INT_MASK_RESET
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       por_active,
   input  wire logic       uvlo_in,
   input  wire logic       ovlo_in,
   input  wire logic       thermal_overload_flag_in,
   input  wire logic       active_low_wake_input,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            interrupt_request_out_n_o,
   output logic            interrupt_request_out_n_oe,
   output logic            pullup_enable,
   output logic            bias_enable,
   output logic            port_enable,
   output logic            seq_outputs_enable,
   output logic            forced_outputs_enable
);

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [4:0] sync1;
   logic [4:0] sync2;
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1 <= 5'h18; // Faults idle low: no false cause flags
         sync2 <= 5'h18;
      end else begin
         sync1 <= {active_low_wake_input, por_active, uvlo_in, ovlo_in, thermal_overload_flag_in};
         sync2 <= sync1;
      end
   end
   logic wake_s, por_s, uvlo_s, ovlo_s, thermal_overload_flag_s;
   assign {wake_s, por_s, uvlo_s, ovlo_s, thermal_overload_flag_s} = sync2;

   // ************************************************************
   // Registers and state declarations
   // ************************************************************
   logic [4:0]             global_config_a, next_global_config_a;
   logic [2:0]             global_config_b, next_global_config_b;
   logic [3:0]             reset_cause_flags, next_reset_cause_flags;
   logic [INT_NUM-1:0]     int_flags, next_int_flags;
   logic [INT_NUM-1:0]     int_mask, next_int_mask;
   logic [7:0]             next_reg_rdata;
   poc_state_t             state, next_state;
   logic [32:0]            hold_cnt, next_hold_cnt;
   logic [15:0]            seq_cnt, next_seq_cnt;
   logic                   wake_flag, next_wake_flag;
   logic                   to_standby, next_to_standby;
   logic                   filt, filt_d, next_filt_d;
   logic [23:0]            db_period;

   wire logic [1:0] mode = global_config_a[CFGA_MODE_LSB +: 2];
   wire logic [1:0] dbt  = global_config_a[CFGA_DBT_LSB +: 2];
   wire logic       is_logic = (mode == MODE_LOGIC);

   // Debounce length doubles per setting step
   always_comb begin
      db_period = 24'(DB_CYC_0) << dbt;
   end

   poc_debounce #(
      .CNT_W (24)
   ) u_debounce (
      .clk      (clk),
      .srst     (srst),
      .raw_in   (wake_s),
      .bypass   (is_logic),
      .period   (db_period),
      .filt_out (filt)
   );

   wire logic fall_ev = filt_d & ~filt;
   wire logic rise_ev = ~filt_d & filt;
   wire logic cmd_wr  = reg_wr && (reg_addr == ADDR_GLOBAL_CONFIG_B);
   wire logic [2:0] cmd = reg_wdata[CFGB_CMD_LSB +: 3];
   wire logic faults  = uvlo_s | ovlo_s | thermal_overload_flag_s;

   // ************************************************************
   // Manual reset detection
   // ************************************************************
   logic manual_reset_flag_hit;
   logic manual_reset_flag_active_lvl;
   always_comb begin
      manual_reset_flag_hit = 1'b0;
      // Slide switch: idle is low, so high is the reset level
      manual_reset_flag_active_lvl = (mode == MODE_SLIDE_SWITCH) ? filt : ~filt;
      next_hold_cnt = '0;
      if (state == ST_RES_ON) begin
         if (is_logic) begin
            manual_reset_flag_hit = filt;
         end else if (manual_reset_flag_active_lvl) begin
            if (hold_cnt >= 33'(MANUAL_RESET_FLAG_HOLD - 1)) begin
               manual_reset_flag_hit = 1'b1;
            end else begin
               next_hold_cnt = hold_cnt + 1'b1;
            end
         end
         // Idle level leaves next_hold_cnt at zero: restart
      end
   end

   // ************************************************************
   // Controller state machine
   // ************************************************************
   logic wake_req;
   always_comb begin
      next_state     = state;
      next_seq_cnt   = '0;
      next_wake_flag = wake_flag;
      next_to_standby = to_standby;
      // Debounced edge in switch modes, low level in logic mode
      wake_req = is_logic ? ~filt : fall_ev;
      case (state)
         ST_RESET: begin
            if (!por_s) begin
               next_state = ST_SHUTDOWN;
            end
         end
         ST_SHUTDOWN: begin
            if (wake_req || wake_flag) begin
               next_state     = ST_CHECK;
               next_wake_flag = 1'b0;
            end
         end
         ST_CHECK: begin
            next_state = faults ? ST_SHUTDOWN : ST_POWER_UP;
         end
         ST_POWER_UP: begin
            next_seq_cnt = seq_cnt + 1'b1;
            if (faults) begin
               next_state = ST_SHUTDOWN;
            end else if (seq_cnt >= 16'(SEQ_CYC - 1)) begin
               next_state = ST_RES_ON;
            end
         end
         ST_RES_ON: begin
            // Decided here so a stale command value never redirects a manual reset
            next_to_standby = !manual_reset_flag_hit && cmd_wr && (cmd == CMD_STANDBY);
            if (faults) begin
               next_state = ST_SHUTDOWN;
            end else if (manual_reset_flag_hit) begin
               next_state = ST_POWER_DN;
            end else if (cmd_wr && (cmd == CMD_COLD_RESET)) begin
               next_state     = ST_POWER_DN;
               next_wake_flag = 1'b1;
            end else if (cmd_wr && (cmd == CMD_POWER_OFF)) begin
               next_state = ST_POWER_DN;
            end else if (cmd_wr && (cmd == CMD_STANDBY)) begin
               next_state = ST_POWER_DN;
            end
         end
         ST_POWER_DN: begin
            next_seq_cnt = seq_cnt + 1'b1;
            if (seq_cnt >= 16'(SEQ_CYC - 1)) begin
               next_state = to_standby ? ST_STANDBY : ST_SHUTDOWN;
            end
         end
         ST_STANDBY: begin
            if (faults) begin
               next_state = ST_SHUTDOWN;
            end else if ((cmd_wr && (cmd == CMD_EXIT_STANDBY)) || (!is_logic && fall_ev)) begin
               next_state = ST_CHECK;
            end
         end
         default: begin
            next_state = ST_RESET;
         end
      endcase
      if (por_s) begin
         next_state = ST_RESET;
      end
   end

   // ************************************************************
   // Register file next values
   // ************************************************************
   always_comb begin
      next_global_config_a   = global_config_a;
      next_global_config_b   = global_config_b;
      next_reset_cause_flags = reset_cause_flags;
      next_int_mask          = int_mask;
      next_int_flags         = int_flags;
      next_reg_rdata         = 8'h00;
      next_filt_d            = filt;
      // Writes are ignored while bias is off, though reads still answer; flags kept anyway
      if (reg_wr && port_enable) begin
         case (reg_addr)
            ADDR_GLOBAL_CONFIG_A: next_global_config_a = reg_wdata[4:0];
            ADDR_GLOBAL_CONFIG_B: next_global_config_b = cmd;
            ADDR_RESET_CAUSE:     next_reset_cause_flags = reset_cause_flags & ~reg_wdata[3:0];
            ADDR_INT_FLAGS:       next_int_flags = int_flags & ~reg_wdata[INT_NUM-1:0];
            ADDR_INT_MASK:        next_int_mask = reg_wdata[INT_NUM-1:0];
            default: ;
         endcase
      end
      // Hardware sets win over software clears
      if (manual_reset_flag_hit) begin
         next_reset_cause_flags[RCF_MANUAL_RESET_FLAG_BIT] = 1'b1;
      end
      if (uvlo_s) next_reset_cause_flags[RCF_UVLO_BIT] = 1'b1;
      if (ovlo_s) next_reset_cause_flags[RCF_OVLO_BIT] = 1'b1;
      if (thermal_overload_flag_s) next_reset_cause_flags[RCF_THERMAL_OVERLOAD_FLAG_BIT] = 1'b1;
      if (fall_ev) next_int_flags[INT_WAKE_F_BIT] = 1'b1;
      if (rise_ev) next_int_flags[INT_WAKE_R_BIT] = 1'b1;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_GLOBAL_CONFIG_A: next_reg_rdata = {3'h0, global_config_a};
            ADDR_GLOBAL_CONFIG_B: next_reg_rdata = {5'h00, global_config_b};
            ADDR_RESET_CAUSE:     next_reg_rdata = {4'h0, reset_cause_flags};
            ADDR_INT_FLAGS:       next_reg_rdata = {6'h00, int_flags};
            ADDR_INT_MASK:        next_reg_rdata = {6'h00, int_mask};
            ADDR_STATUS:          next_reg_rdata = {4'h0, filt, state};
            default:              next_reg_rdata = 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // srst is the chip reset; the cause flags survive shutdown
   always_ff @(posedge clk) begin
      if (srst) begin
         state             <= ST_RESET;
         hold_cnt          <= '0;
         seq_cnt           <= '0;
         wake_flag         <= 1'b0;
         to_standby        <= 1'b0;
         filt_d            <= 1'b1;
         global_config_a   <= CFGA_RESET;
         global_config_b   <= 3'h0;
         reset_cause_flags <= 4'h0;
         int_flags         <= '0;
         int_mask          <= MASK_INIT;
         reg_rdata         <= 8'h00;
      end else begin
         state             <= next_state;
         hold_cnt          <= next_hold_cnt;
         seq_cnt           <= next_seq_cnt;
         wake_flag         <= next_wake_flag;
         to_standby        <= next_to_standby;
         filt_d            <= next_filt_d;
         global_config_a   <= next_global_config_a;
         global_config_b   <= next_global_config_b;
         reset_cause_flags <= next_reset_cause_flags;
         int_flags         <= next_int_flags;
         int_mask          <= next_int_mask;
         reg_rdata         <= next_reg_rdata;
      end
   end

   // ************************************************************
   // Registered outputs
   // ************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         interrupt_request_out_n_o  <= 1'b0;
         interrupt_request_out_n_oe <= 1'b0;
         pullup_enable              <= 1'b0;
         bias_enable                <= 1'b0;
         port_enable                <= 1'b0;
         seq_outputs_enable         <= 1'b0;
         forced_outputs_enable      <= 1'b0;
      end else begin
         interrupt_request_out_n_o  <= 1'b0;
         interrupt_request_out_n_oe <= |(next_int_flags & ~next_int_mask);
         pullup_enable              <= ~next_global_config_a[CFGA_PUD_BIT];
         bias_enable                <= (next_state != ST_SHUTDOWN) && (next_state != ST_RESET);
         port_enable                <= (next_state != ST_SHUTDOWN) && (next_state != ST_RESET);
         seq_outputs_enable         <= (next_state == ST_RES_ON);
         forced_outputs_enable      <= (next_state == ST_RES_ON) || (next_state == ST_STANDBY);
      end
   end

endmodule : poc_controller
`default_nettype wire

// >>> src/poc_debounce.sv
// Two-edge debounce filter for the wake input
`timescale 1ns/10ps
`default_nettype none
module poc_debounce
   import poc_pkg::*;
#(
   parameter int CNT_W = 24
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             raw_in,
   input  wire logic             bypass,
   input  wire logic [CNT_W-1:0] period,
   output var  logic             filt_out
);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             next_filt_out;

   // Output follows after a full stable period, both edges; at once when bypassed
   always_comb begin
      next_cnt      = '0;
      next_filt_out = filt_out;
      if (bypass) begin
         next_filt_out = raw_in;
      end else if (raw_in != filt_out) begin
         if (cnt >= period - 1'b1) begin
            next_filt_out = raw_in;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   // Idle level high: input is active low
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt      <= '0;
         filt_out <= 1'b1;
      end else begin
         cnt      <= next_cnt;
         filt_out <= next_filt_out;
      end
   end

endmodule : poc_debounce
`default_nettype wire

// >>> src/poc_pkg.sv
// Package with register map, field layouts and timing constants of the on/off controller
package poc_pkg;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADDR_GLOBAL_CONFIG_A = 8'h00;
   localparam logic [7:0] ADDR_GLOBAL_CONFIG_B = 8'h04;
   localparam logic [7:0] ADDR_RESET_CAUSE     = 8'h08;
   localparam logic [7:0] ADDR_INT_FLAGS       = 8'h0C;
   localparam logic [7:0] ADDR_INT_MASK        = 8'h10;
   localparam logic [7:0] ADDR_STATUS          = 8'h14;

   // ************************************************************
   // Field positions
   // ************************************************************
   // global_config_a: [1:0] wake_input_mode, [3:2] wake_debounce_time, [4] pullup_disable
   localparam int CFGA_MODE_LSB = 0;
   localparam int CFGA_DBT_LSB  = 2;
   localparam int CFGA_PUD_BIT  = 4;
   // global_config_b: [2:0] software_control_command (keeps the last value written)
   localparam int CFGB_CMD_LSB  = 0;
   // reset_cause_flags bits
   localparam int RCF_MANUAL_RESET_FLAG_BIT  = 0;
   localparam int RCF_UVLO_BIT  = 1;
   localparam int RCF_OVLO_BIT  = 2;
   localparam int RCF_THERMAL_OVERLOAD_FLAG_BIT = 3;
   // interrupt flag bits
   localparam int INT_WAKE_F_BIT = 0;
   localparam int INT_WAKE_R_BIT = 1;
   localparam int INT_NUM        = 2;

   // ************************************************************
   // Encodings and reset values
   // ************************************************************
   localparam logic [1:0] MODE_PUSH_BUTTON  = 2'h0;
   localparam logic [1:0] MODE_SLIDE_SWITCH = 2'h1;
   localparam logic [1:0] MODE_LOGIC        = 2'h2;
   localparam logic [2:0] CMD_COLD_RESET    = 3'h1;
   localparam logic [2:0] CMD_POWER_OFF     = 3'h2;
   localparam logic [2:0] CMD_STANDBY       = 3'h3;
   localparam logic [2:0] CMD_EXIT_STANDBY  = 3'h4;
   localparam logic [4:0] CFGA_RESET        = 5'h02;
   localparam logic [1:0] INT_MASK_RESET    = 2'h3;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_HZ          = 50_000_000;
   localparam int DEBOUNCE_US_0   = 100;
   localparam int DEBOUNCE_CYC_0  = (DEBOUNCE_US_0 * (CLK_HZ / 1_000_000));
   localparam int MANUAL_RESET_FLAG_HOLD_S     = 8;
   localparam longint MANUAL_RESET_FLAG_HOLD_CYC = longint'(MANUAL_RESET_FLAG_HOLD_S) * longint'(CLK_HZ);
   localparam int SEQ_STEP_CYC    = 16;

   // ************************************************************
   // Controller states
   // ************************************************************
   typedef enum logic [2:0] {
      ST_RESET     = 3'b000,
      ST_SHUTDOWN  = 3'b001,
      ST_CHECK     = 3'b011,
      ST_POWER_UP  = 3'b010,
      ST_RES_ON    = 3'b110,
      ST_POWER_DN  = 3'b111,
      ST_STANDBY   = 3'b101
   } poc_state_t;

endpackage : poc_pkg

// >>> tb/poc_controller_chk.sv
// Port-level checker for the on/off controller
`timescale 1ns/10ps
`default_nettype none
module poc_controller_chk
   import poc_pkg::*;
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       por_active,
   input wire logic       uvlo_in,
   input wire logic       ovlo_in,
   input wire logic       thermal_overload_flag_in,
   input wire logic       active_low_wake_input,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       interrupt_request_out_n_o,
   input wire logic       interrupt_request_out_n_oe,
   input wire logic       pullup_enable,
   input wire logic       bias_enable,
   input wire logic       port_enable,
   input wire logic       seq_outputs_enable,
   input wire logic       forced_outputs_enable
);
   // ************************************************************
   // Properties on the output ports
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire logic fault = uvlo_in | ovlo_in | thermal_overload_flag_in;

   chk_irq_open_drain: assert property (interrupt_request_out_n_o == 1'b0)
      else $error("interrupt pin data is not low");
   chk_seq_needs_bias: assert property (seq_outputs_enable |-> bias_enable && port_enable && forced_outputs_enable)
      else $error("sequenced outputs on without bias, port or forced outputs");
   chk_por_holds_off: assert property (por_active [*6] |-> !bias_enable)
      else $error("bias on while supply below threshold");
   chk_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside the answer cycle");
   chk_fault_blocks_up: assert property (fault [*8] |-> !$rose(seq_outputs_enable))
      else $error("power up completed with a fault present");
   chk_pullup_follows: assert property (reg_wr && port_enable && reg_addr == ADDR_GLOBAL_CONFIG_A
      |-> ##2 pullup_enable == !$past(reg_wdata[CFGA_PUD_BIT], 2))
      else $error("pullup enable does not follow the written setting");
   chk_powerup_span: assert property ($rose(seq_outputs_enable) |-> $past(bias_enable, 17))
      else $error("resource on reached without a power-up sequence");
   chk_shutdown_port_off: assert property (!bias_enable |-> !port_enable)
      else $error("register port on while bias is off");

   // Main scenarios seen
   cov_power_up: cover property ($rose(seq_outputs_enable));
   cov_standby: cover property (forced_outputs_enable && !seq_outputs_enable);
   cov_irq: cover property ($rose(interrupt_request_out_n_oe));
endmodule : poc_controller_chk
`default_nettype wire

// >>> tb/poc_onkey_model.sv
// Behavioural on-key and host model for the wake and interrupt pins
`timescale 1ns/10ps
`default_nettype none
module poc_onkey_model (
   input  wire logic clk,
   input  wire logic drive_en,
   input  wire logic drive_lvl,
   input  wire logic pullup_enable,
   input  wire logic irq_oe,
   output var  logic pin,
   output var  logic irq_n
);
   // ************************************************************
   // Pin resolution
   // ************************************************************
   logic wander = 1'b0;
   // A floating node wanders so a stale level is never trusted
   always @(posedge clk) begin
      wander <= ~wander;
   end
   // Released key reads the internal pullup or floats
   always_comb begin
      if (drive_en) pin = drive_lvl;
      else if (pullup_enable) pin = 1'b1;
      else pin = wander;
      irq_n = irq_oe ? 1'b0 : 1'b1;
   end
endmodule : poc_onkey_model
`default_nettype wire

// >>> tb/power_onoff_controller_test.sv
// Self-checking testbench for the on/off controller
`timescale 1ns/10ps
`default_nettype none
module power_onoff_controller_test;
   import poc_pkg::*;
   logic clk = 1'b0, srst = 1'b1, por = 1'b1, uvlo = 1'b0, ovlo = 1'b0, thermal_overload_flag = 1'b0;
   logic drv_en = 1'b1, drv_lvl = 1'b0, wr = 1'b0, rd = 1'b0, pin, irq_n;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic irq_o, irq_oe, pue, bias, port, seq_en, forced;
   int n_fail = 0, cmp_count = 0, cycles = 0;

   poc_controller #(.MANUAL_RESET_FLAG_HOLD(50), .DB_CYC_0(4)) dut (.clk(clk), .srst(srst), .por_active(por),
      .uvlo_in(uvlo), .ovlo_in(ovlo), .thermal_overload_flag_in(thermal_overload_flag), .active_low_wake_input(pin), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .interrupt_request_out_n_o(irq_o),
      .interrupt_request_out_n_oe(irq_oe), .pullup_enable(pue), .bias_enable(bias), .port_enable(port),
      .seq_outputs_enable(seq_en), .forced_outputs_enable(forced));
   poc_onkey_model key (.clk(clk), .drive_en(drv_en), .drive_lvl(drv_lvl), .pullup_enable(pue),
      .irq_oe(irq_oe), .pin(pin), .irq_n(irq_n));

   // ************************************************************
   // Clock, timeout and helpers
   // ************************************************************
   initial begin
      forever #10 clk = ~clk;
   end
   // Ceiling well above the fewer than 1000 cycles the tests take
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   // Read data stand only in the cycle after the strobe
   task automatic rreg(input string name, input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(name, rdata & m, exp);
   endtask : rreg
   function automatic logic pick(input int s);
      case (s)
         0: return seq_en;
         1: return bias;
         2: return !irq_n; // Seen through the host pin model
         3: return forced;
         default: return pue;
      endcase
   endfunction : pick
   task automatic wait_for(input string name, input int s, input logic v, input int lim);
      int i;
      #1 i = 0; // Let the launching edge settle
      while (pick(s) !== v && i < lim) begin
         @(posedge clk);
         #1 i++;
      end
      check(name, {7'h00, pick(s)}, {7'h00, v});
   endtask : wait_for
   task automatic hold(input string name, input int s, input logic v, input int n);
      repeat (n) begin
         @(posedge clk);
         #1 check(name, {7'h00, pick(s)}, {7'h00, v});
      end
   endtask : hold
   task automatic key_set(input logic en, input logic lvl);
      @(posedge clk);
      drv_en <= en;
      drv_lvl <= lvl;
   endtask : key_set

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check("pullup after reset", {7'h00, pue}, 8'h01);
      hold("off below por", 1, 1'b0, 20);
      rreg("cfg_a reset", ADDR_GLOBAL_CONFIG_A, 8'h02, 8'h1F);
      rreg("mask reset", ADDR_INT_MASK, 8'h03, 8'h03);
      rreg("state reset", ADDR_STATUS, 8'(ST_RESET), 8'h07);
      rreg("cause reset", ADDR_RESET_CAUSE, 8'h00, 8'h0F);
      @(posedge clk);
      por <= 1'b0;
      wait_for("power up", 0, 1'b1, 80);
      rreg("state on", ADDR_STATUS, 8'(ST_RES_ON), 8'h07);
      wreg(ADDR_INT_MASK, 8'h00);
      wreg(ADDR_INT_FLAGS, 8'h03);
      wait_for("irq idle", 2, 1'b0, 5);
      wreg(ADDR_GLOBAL_CONFIG_B, {5'h00, CMD_STANDBY});
      wait_for("standby seq off", 0, 1'b0, 40);
      wait_for("standby reached", 3, 1'b1, 40);
      hold("standby forced on", 3, 1'b1, 2);
      rreg("state standby", ADDR_STATUS, 8'(ST_STANDBY), 8'h07);
      wreg(ADDR_GLOBAL_CONFIG_B, {5'h00, CMD_EXIT_STANDBY});
      wait_for("exit standby", 0, 1'b1, 40);
      key_set(1'b0, 1'b0);
      wait_for("logic high off", 1, 1'b0, 40);
      rreg("manual_reset_flag flag logic", ADDR_RESET_CAUSE, 8'h01, 8'h01);
      key_set(1'b1, 1'b0);
      wait_for("logic low wake", 0, 1'b1, 60);
      wreg(ADDR_RESET_CAUSE, 8'h0F);
      wreg(ADDR_GLOBAL_CONFIG_A, 8'h10);
      wait_for("pullup off", 4, 1'b0, 5);
      hold("button before hold", 0, 1'b1, 30);
      wait_for("button hold off", 1, 1'b0, 60);
      rreg("manual_reset_flag flag button", ADDR_RESET_CAUSE, 8'h01, 8'h01);
      key_set(1'b1, 1'b1);
      repeat (20) @(posedge clk);
      key_set(1'b1, 1'b0);
      key_set(1'b1, 1'b1);
      hold("glitch rejected", 1, 1'b0, 40);
      key_set(1'b1, 1'b0);
      wait_for("button wake", 0, 1'b1, 80);
      key_set(1'b1, 1'b1);
      repeat (10) @(posedge clk);
      wreg(ADDR_INT_FLAGS, 8'h03);
      wait_for("irq cleared", 2, 1'b0, 5);
      key_set(1'b1, 1'b0);
      wait_for("irq on fall", 2, 1'b1, 20);
      wreg(ADDR_INT_MASK, 8'h03);
      wait_for("irq masked", 2, 1'b0, 5);
      wreg(ADDR_GLOBAL_CONFIG_A, 8'h11);
      key_set(1'b1, 1'b1);
      repeat (20) @(posedge clk);
      key_set(1'b1, 1'b0);
      repeat (10) @(posedge clk);
      key_set(1'b1, 1'b1);
      hold("hold restarted", 0, 1'b1, 35);
      wait_for("slide hold off", 1, 1'b0, 60);
      key_set(1'b1, 1'b0);
      wait_for("slide wake", 0, 1'b1, 80);
      wreg(ADDR_GLOBAL_CONFIG_B, {5'h00, CMD_STANDBY});
      wait_for("slide standby", 0, 1'b0, 40);
      key_set(1'b1, 1'b1);
      repeat (30) @(posedge clk);
      key_set(1'b1, 1'b0);
      wait_for("slide standby exit", 0, 1'b1, 80);
      key_set(1'b1, 1'b1);
      wait_for("manual_reset_flag after standby", 1, 1'b0, 100);
      key_set(1'b1, 1'b0);
      wait_for("wake after manual_reset_flag", 0, 1'b1, 80);
      wreg(ADDR_GLOBAL_CONFIG_B, {5'h00, CMD_COLD_RESET});
      wait_for("cold reset down", 0, 1'b0, 40);
      wait_for("cold reset up", 0, 1'b1, 100);
      wreg(ADDR_GLOBAL_CONFIG_B, {5'h00, CMD_POWER_OFF});
      wait_for("power off", 1, 1'b0, 40);
      hold("stays off", 1, 1'b0, 40);
      key_set(1'b1, 1'b1);
      uvlo <= 1'b1;
      repeat (10) @(posedge clk);
      key_set(1'b1, 1'b0);
      hold("fault blocks", 0, 1'b0, 60);
      key_set(1'b1, 1'b1);
      uvlo <= 1'b0;
      repeat (10) @(posedge clk);
      key_set(1'b1, 1'b0);
      wait_for("fault cleared", 0, 1'b1, 80);
      rreg("unmapped", 8'hFC, 8'h00, 8'hFF);
      complete_run();
   end
endmodule : power_onoff_controller_test

bind poc_controller poc_controller_chk chk_i (.clk(clk), .srst(srst), .por_active(por_active),
   .uvlo_in(uvlo_in), .ovlo_in(ovlo_in), .thermal_overload_flag_in(thermal_overload_flag_in), .active_low_wake_input(active_low_wake_input),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .interrupt_request_out_n_o(interrupt_request_out_n_o), .interrupt_request_out_n_oe(interrupt_request_out_n_oe),
   .pullup_enable(pullup_enable), .bias_enable(bias_enable), .port_enable(port_enable),
   .seq_outputs_enable(seq_outputs_enable), .forced_outputs_enable(forced_outputs_enable));
`default_nettype wire
